// ==== hw/pmmc_pkg.sv ====
package pmmc_pkg;

    localparam int unsigned PMMC_ADDR_W = 8;

    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [7:0] PMMC_OFF_LOCK    = 8'h00;
    localparam logic [7:0] PMMC_OFF_MODE    = 8'h04;
    localparam logic [7:0] PMMC_OFF_MISC    = 8'h08;
    localparam logic [7:0] PMMC_OFF_STATUS  = 8'h0c;
    localparam logic [7:0] PMMC_OFF_SYSCFG  = 8'h10;
    localparam logic [7:0] PMMC_OFF_DIV     = 8'h14;
    localparam logic [7:0] PMMC_OFF_RADDR   = 8'h18;
    localparam logic [7:0] PMMC_OFF_WDATA_L = 8'h1c;
    localparam logic [7:0] PMMC_OFF_WDATA_H = 8'h20;
    localparam logic [7:0] PMMC_OFF_CMD     = 8'h24;
    localparam logic [7:0] PMMC_OFF_RDATA_L = 8'h28;
    localparam logic [7:0] PMMC_OFF_RDATA_H = 8'h2c;

    // Field positions.
    localparam int unsigned PMMC_MISC_RST_BIT   = 0;
    localparam int unsigned PMMC_MISC_TE_BIT    = 3;
    localparam int unsigned PMMC_MISC_PHY_POWER_DOWN_BIT_BIT  = 5;
    localparam int unsigned PMMC_SYSCFG_SYSTEM_CLOCK_SELECT  = 0;
    localparam int unsigned PMMC_MODE_FORCED    = 2;
    localparam int unsigned PMMC_STAT_MODE_LSB  = 3;

    // Key and command codes.
    localparam logic [7:0] PMMC_UNLOCK_KEY = 8'h53;
    localparam logic [7:0] PMMC_CMD_IDLE   = 8'h00;
    localparam logic [7:0] PMMC_CMD_WRITE  = 8'h01;
    localparam logic [7:0] PMMC_CMD_READ   = 8'h02;

    // Mode field codes.
    localparam logic [2:0] PMMC_MODE_AUTO  = 3'h0;
    localparam logic [2:0] PMMC_MODE_100F  = 3'h4;
    localparam logic [2:0] PMMC_MODE_100H  = 3'h5;
    localparam logic [2:0] PMMC_MODE_10F   = 3'h6;
    localparam logic [2:0] PMMC_MODE_10H   = 3'h7;

    // Reset values.
    localparam logic [7:0] PMMC_RST_BYTE   = 8'h00;
    localparam logic [4:0] PMMC_PHY_ADDR   = 5'h00;

    localparam logic [1:0] PMMC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PMMC_RESP_SLVERR = 2'h2;

    // Timing.
    localparam int unsigned PMMC_CLK_NS     = 40;
    localparam int unsigned PMMC_PHY_RST_NS = 600000;
    localparam int unsigned PMMC_PHY_RST_CYC =
        (PMMC_PHY_RST_NS + PMMC_CLK_NS - 1) / PMMC_CLK_NS;

    // Management frame layout, clause 22.
    localparam logic [6:0] PMMC_FRAME_LAST = 7'd63;
    localparam logic [6:0] PMMC_TA_POS     = 7'd46;
    localparam logic [6:0] PMMC_DATA_POS   = 7'd48;
    localparam logic [31:0] PMMC_PREAMBLE  = 32'hffffffff;
    localparam logic [1:0] PMMC_ST         = 2'h1;
    localparam logic [1:0] PMMC_OP_WR      = 2'h1;
    localparam logic [1:0] PMMC_OP_RD      = 2'h2;
    localparam logic [1:0] PMMC_TA_WR      = 2'h2;

    typedef struct packed {
        logic [2:0] op_mode;
        logic [2:0] link_state;
    } pmmc_phy_stat_t;

    typedef struct packed {
        logic reset_n;
        logic power_down;
        logic low_amp_10m;
        logic autoneg;
        logic parallel_detect_en;
        logic auto_mdix_en;
        logic speed_100;
        logic full_duplex;
        logic system_clock_fast_sel;
    } pmmc_phy_ctl_t;

    typedef struct packed {
        logic       speed_100;
        logic       full_duplex;
    } pmmc_mode_dec_t;

    function automatic pmmc_mode_dec_t pmmc_decode_mode(input logic [2:0] m);
        pmmc_mode_dec_t d;
        d.speed_100   = 1'b1;
        d.full_duplex = 1'b1;
        unique case (m)
            PMMC_MODE_100H: d.full_duplex = 1'b0;
            PMMC_MODE_10F:  d.speed_100 = 1'b0;
            PMMC_MODE_10H: begin
                d.speed_100   = 1'b0;
                d.full_duplex = 1'b0;
            end
            default: d = d;
        endcase
        return d;
    endfunction

endpackage

// ==== hw/pmmc_sync.sv ====
`timescale 1ns/10ps
module pmmc_sync import pmmc_pkg::*; #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pmmc_sync_st_t;

    pmmc_sync_st_t s_r;
    pmmc_sync_st_t s_nxt;

    always_comb begin
        s_nxt.meta   = d;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.stable;
endmodule

// ==== hw/pmmc_mdio.sv ====
`timescale 1ns/10ps
module pmmc_mdio import pmmc_pkg::*; (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        start_wr,
    input  wire logic        start_rd,
    input  wire logic [4:0]  phy_addr,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] wdata,
    input  wire logic [7:0]  div,
    input  wire logic        mdio_in,
    output logic             done,
    output logic [15:0]      rdata,
    output logic             mdc,
    output logic             mdio_o,
    output logic             mdio_oe
);
    typedef struct packed {
        logic        busy;
        logic        is_rd;
        logic        done;
        logic        mdc;
        logic        mdio_o;
        logic        mdio_oe;
        logic [7:0]  cnt;
        logic [6:0]  bitn;
        logic [63:0] sh;
        logic [15:0] rdata;
    } pmmc_mdio_st_t;

    pmmc_mdio_st_t s_r;
    pmmc_mdio_st_t s_nxt;

    // Frame bits go out MSB first; each bit changes on the MDC falling edge.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (!s_r.busy) begin
            if (start_wr || start_rd) begin
                s_nxt.busy    = 1'b1;
                s_nxt.is_rd   = start_rd;
                s_nxt.cnt     = 8'h00;
                s_nxt.bitn    = 7'd0;
                s_nxt.mdc     = 1'b0;
                s_nxt.sh      = {PMMC_PREAMBLE, PMMC_ST, start_rd ? PMMC_OP_RD : PMMC_OP_WR,
                                 phy_addr, reg_addr, PMMC_TA_WR, wdata};
                s_nxt.mdio_o  = 1'b1;
                s_nxt.mdio_oe = 1'b1;
            end
        end else if (s_r.cnt == div) begin
            s_nxt.cnt = 8'h00;
            s_nxt.mdc = !s_r.mdc;
            if (s_r.mdc) begin
                // Sampling at the end of the high phase leaves room for the synchroniser.
                if (s_r.is_rd && s_r.bitn >= PMMC_DATA_POS) begin
                    s_nxt.rdata = {s_r.rdata[14:0], mdio_in};
                end
                if (s_r.bitn == PMMC_FRAME_LAST) begin
                    s_nxt.busy    = 1'b0;
                    s_nxt.done    = 1'b1;
                    s_nxt.mdc     = 1'b0;
                    s_nxt.mdio_oe = 1'b0;
                end else begin
                    s_nxt.bitn    = s_r.bitn + 7'd1;
                    s_nxt.sh      = {s_r.sh[62:0], 1'b0};
                    s_nxt.mdio_o  = s_r.sh[62];
                    s_nxt.mdio_oe = !s_r.is_rd || ((s_r.bitn + 7'd1) < PMMC_TA_POS);
                end
            end
        end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done    = s_r.done;
    assign rdata   = s_r.rdata;
    assign mdc     = s_r.mdc;
    assign mdio_o  = s_r.mdio_o;
    assign mdio_oe = s_r.mdio_oe;
endmodule

// ==== hw/pmmc_top.sv ====
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
// Notes on behaviour
// - A new speed/duplex setting reaches the PHY only through a PHY hard reset.
// - Status shows link state in bits 2:0, and operating mode in bits 5:3 only while link state bit 0 is set (else 000).
// - Mode register writes land only while the lock is open.
// - Writing 0x53 to the lock opens both control registers; anything else closes.
// - Mode codes: 000 auto, 100/101 100M full/half, 110/111 10M full/half.
// - In auto mode the PHY may link by parallel detection.
// - Crossover detection runs only when the mode top bit is zero.
// - Power-down bit set powers the PHY down and forces slow system clock.
// - Power-down bit cleared restores normal PHY and clock-select choice.
// - A management controller reaches PHY registers through host registers.
// - Write word is high byte plus low byte registers.
// - Command 0x01 writes the word to the PHY, then command clears.
// - Command 0x02 reads the PHY register into read bytes, then command clears.
// - Read word's high byte and low byte sit in separate registers.
module pmmc_top import pmmc_pkg::*; #(
    parameter int unsigned PHY_RST_CYCLES = PMMC_PHY_RST_CYC
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [PMMC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    output logic [1:0]                  s_axi_bresp,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    input  wire logic [PMMC_ADDR_W-1:0] s_axi_araddr,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    input  wire pmmc_phy_stat_t         phy_stat,
    output pmmc_phy_ctl_t               phy_ctl,
    output logic                        mdc,
    input  wire logic                   mdio_i,
    output logic                        mdio_o,
    output logic                        mdio_oe
);
    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
        logic                   aw_hold;
        logic [PMMC_ADDR_W-1:0] awaddr;
        logic                   w_hold;
        logic [7:0]             wdata;
        logic                   wlane;
        logic                   unlocked;
        logic [2:0]             mode_cfg;
        logic [2:0]             mode_applied;
        logic                   rst_bit;
        logic [15:0]            rst_cnt;
        logic                   te;
        logic                   phy_power_down_bit;
        logic                   system_clock_select;
        logic [7:0]             div;
        logic [7:0]             raddr;
        logic [7:0]             wd_lo;
        logic [7:0]             wd_hi;
        logic [7:0]             cmd;
        logic [7:0]             rd_lo;
        logic [7:0]             rd_hi;
        logic                   start_wr;
        logic                   start_rd;
        pmmc_phy_ctl_t          ctl;
    } pmmc_top_st_t;

    localparam logic [15:0] RST_LOAD = PHY_RST_CYCLES[15:0];

    pmmc_top_st_t   s_r;
    pmmc_top_st_t   s_nxt;
    pmmc_phy_stat_t stat_s;
    logic           mdio_s;
    logic           mdio_done;
    logic [15:0]    mdio_rdata;

    pmmc_sync #(.WIDTH(7)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({phy_stat, mdio_i}),
        .q       ({stat_s, mdio_s})
    );

    pmmc_mdio u_mdio (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start_wr (s_r.start_wr),
        .start_rd (s_r.start_rd),
        .phy_addr (PMMC_PHY_ADDR),
        .reg_addr (s_r.raddr[4:0]),
        .wdata    ({s_r.wd_hi, s_r.wd_lo}),
        .div      (s_r.div),
        .mdio_in  (mdio_s),
        .done     (mdio_done),
        .rdata    (mdio_rdata),
        .mdc      (mdc),
        .mdio_o   (mdio_o),
        .mdio_oe  (mdio_oe)
    );

    function automatic logic [7:0] misc_byte(input logic rst, input logic te,
                                             input logic phy_power_down_bit);
        logic [7:0] b;
        b = 8'h00;
        b[PMMC_MISC_RST_BIT]  = rst;
        b[PMMC_MISC_TE_BIT]   = te;
        b[PMMC_MISC_PHY_POWER_DOWN_BIT_BIT] = phy_power_down_bit;
        return b;
    endfunction

    // Read decode: bit 8 flags a mapped address, bits 7:0 carry the byte.
    function automatic logic [8:0] read_reg(input pmmc_top_st_t s, input pmmc_phy_stat_t st,
                                            input logic [PMMC_ADDR_W-1:0] a);
        logic [7:0] b;
        logic       ok;
        b  = 8'h00;
        ok = 1'b1;
        unique case (a)
            PMMC_OFF_LOCK:    b = 8'h00;
            PMMC_OFF_MODE:    b = {5'h00, s.mode_cfg};
            PMMC_OFF_MISC:    b = misc_byte(s.rst_bit, s.te, s.phy_power_down_bit);
            PMMC_OFF_STATUS: begin
                b[2:0] = st.link_state;
                if (st.link_state[0]) begin
                    b[PMMC_STAT_MODE_LSB +: 3] = st.op_mode;
                end
            end
            PMMC_OFF_SYSCFG: b[PMMC_SYSCFG_SYSTEM_CLOCK_SELECT] = s.system_clock_select;
            PMMC_OFF_DIV:     b = s.div;
            PMMC_OFF_RADDR:   b = s.raddr;
            PMMC_OFF_WDATA_L: b = s.wd_lo;
            PMMC_OFF_WDATA_H: b = s.wd_hi;
            PMMC_OFF_CMD:     b = s.cmd;
            PMMC_OFF_RDATA_L: b = s.rd_lo;
            PMMC_OFF_RDATA_H: b = s.rd_hi;
            default:          ok = 1'b0;
        endcase
        return {ok, b};
    endfunction

    logic [8:0]     rd_word;
    logic [8:0]     wr_word;
    pmmc_mode_dec_t dec;

    always_comb begin
        s_nxt          = s_r;
        s_nxt.start_wr = 1'b0;
        s_nxt.start_rd = 1'b0;
        rd_word        = read_reg(s_r, stat_s, s_axi_araddr);
        wr_word        = read_reg(s_r, stat_s, s_r.awaddr);

        // Address and data may arrive in either order; each is held until both are in.
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_hold = 1'b1;
            s_nxt.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_hold = 1'b1;
            s_nxt.wdata  = s_axi_wdata[7:0];
            s_nxt.wlane  = s_axi_wstrb[0];
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
            s_nxt.aw_hold = 1'b0;
            s_nxt.w_hold  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = wr_word[8] ? PMMC_RESP_OKAY : PMMC_RESP_SLVERR;
            if (s_r.wlane) begin
                unique case (s_r.awaddr)
                    PMMC_OFF_LOCK: s_nxt.unlocked = (s_r.wdata == PMMC_UNLOCK_KEY);
                    PMMC_OFF_MODE: begin
                        if (s_r.unlocked) begin
                            s_nxt.mode_cfg = s_r.wdata[2:0];
                        end
                    end
                    PMMC_OFF_MISC: begin
                        if (s_r.unlocked) begin
                            s_nxt.te   = s_r.wdata[PMMC_MISC_TE_BIT];
                            s_nxt.phy_power_down_bit = s_r.wdata[PMMC_MISC_PHY_POWER_DOWN_BIT_BIT];
                            if (s_r.wdata[PMMC_MISC_RST_BIT] && !s_r.rst_bit) begin
                                s_nxt.rst_bit      = 1'b1;
                                s_nxt.rst_cnt      = RST_LOAD;
                                s_nxt.mode_applied = s_r.mode_cfg;
                            end
                        end
                    end
                    PMMC_OFF_SYSCFG:  s_nxt.system_clock_select = s_r.wdata[PMMC_SYSCFG_SYSTEM_CLOCK_SELECT];
                    PMMC_OFF_DIV:     s_nxt.div    = s_r.wdata;
                    PMMC_OFF_RADDR:   s_nxt.raddr  = s_r.wdata;
                    PMMC_OFF_WDATA_L: s_nxt.wd_lo  = s_r.wdata;
                    PMMC_OFF_WDATA_H: s_nxt.wd_hi  = s_r.wdata;
                    PMMC_OFF_CMD: begin
                        if (s_r.cmd == PMMC_CMD_IDLE) begin
                            if (s_r.wdata == PMMC_CMD_WRITE) begin
                                s_nxt.cmd      = s_r.wdata;
                                s_nxt.start_wr = 1'b1;
                            end else if (s_r.wdata == PMMC_CMD_READ) begin
                                s_nxt.cmd      = s_r.wdata;
                                s_nxt.start_rd = 1'b1;
                            end
                        end
                    end
                    default: s_nxt.unlocked = s_r.unlocked;
                endcase
            end
        end
        s_nxt.awready = !s_nxt.aw_hold && !(s_nxt.w_hold && s_nxt.bvalid);
        s_nxt.wready  = !s_nxt.w_hold && !(s_nxt.aw_hold && s_nxt.bvalid);

        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rdata   = {24'h000000, rd_word[7:0]};
            s_nxt.rresp   = rd_word[8] ? PMMC_RESP_OKAY : PMMC_RESP_SLVERR;
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid  = 1'b0;
            s_nxt.arready = 1'b1;
        end else if (!s_r.rvalid) begin
            s_nxt.arready = 1'b1;
        end

        // Completion of the management frame frees the command register.
        if (mdio_done) begin
            s_nxt.cmd = PMMC_CMD_IDLE;
            if (s_r.cmd == PMMC_CMD_READ) begin
                s_nxt.rd_hi = mdio_rdata[15:8];
                s_nxt.rd_lo = mdio_rdata[7:0];
            end
        end

        // The hard reset bit holds the PHY in reset for the settle time, then clears.
        if (s_r.rst_bit) begin
            if (s_r.rst_cnt <= 16'h0001) begin
                s_nxt.rst_bit = 1'b0;
            end else begin
                s_nxt.rst_cnt = s_r.rst_cnt - 16'h0001;
            end
        end

        dec                          = pmmc_decode_mode(s_r.mode_applied);
        s_nxt.ctl.reset_n            = !s_r.rst_bit;
        s_nxt.ctl.autoneg            = !s_r.mode_applied[PMMC_MODE_FORCED];
        s_nxt.ctl.parallel_detect_en = !s_r.mode_applied[PMMC_MODE_FORCED];
        s_nxt.ctl.auto_mdix_en       = !s_r.mode_applied[PMMC_MODE_FORCED];
        s_nxt.ctl.speed_100          = dec.speed_100;
        s_nxt.ctl.full_duplex        = dec.full_duplex;
        s_nxt.ctl.low_amp_10m        = s_r.te;
        s_nxt.ctl.power_down         = s_r.phy_power_down_bit;
        s_nxt.ctl.system_clock_fast_sel   = !s_r.system_clock_select && !s_r.phy_power_down_bit && !s_r.rst_bit;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready  = s_r.wready;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign phy_ctl       = s_r.ctl;
endmodule

// ==== test/pmmc_top_monitor.sv ====
`timescale 1ns/10ps
module pmmc_top_monitor import pmmc_pkg::*; #(
    parameter int unsigned PHY_RST_CYCLES = 20
) (
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire logic          s_axi_awvalid,
    input wire logic          s_axi_awready,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire pmmc_phy_ctl_t phy_ctl,
    input wire logic          mdc,
    input wire logic          mdio_oe
);
    logic [15:0] lo_cnt_r;
    logic        hard_r;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Measures each PHY reset pulse; hard_r marks one started from the control register.
    always_ff @(posedge aclk) begin
        if (!aresetn || phy_ctl.reset_n) begin
            lo_cnt_r <= 16'h0000;
            hard_r   <= 1'h0;
        end else begin
            lo_cnt_r <= lo_cnt_r + 16'h0001;
            hard_r   <= hard_r | $past(phy_ctl.reset_n);
        end
    end
    property p_aw_drop; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_drop: assert property (p_aw_drop) else $error("address ready stayed high");
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_b_gap; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_gap: assert property (p_b_gap) else $error("second response too soon");
    property p_mdix; phy_ctl.reset_n |-> phy_ctl.auto_mdix_en == phy_ctl.autoneg; endproperty
    a_mdix: assert property (p_mdix) else $error("crossover enable wrong");
    property p_pdet; phy_ctl.autoneg |-> phy_ctl.parallel_detect_en; endproperty
    a_pdet: assert property (p_pdet) else $error("parallel detect off in auto");
    property p_phy_power_down_bit; phy_ctl.power_down |-> !phy_ctl.system_clock_fast_sel; endproperty
    a_phy_power_down_bit: assert property (p_phy_power_down_bit) else $error("fast clock in power down");
    property p_mode; $changed({phy_ctl.speed_100, phy_ctl.full_duplex, phy_ctl.autoneg})
        && $past(phy_ctl.reset_n) |=> !phy_ctl.reset_n; endproperty
    a_mode: assert property (p_mode) else $error("mode changed without reset");
    property p_hrst; $rose(phy_ctl.reset_n) && hard_r |-> lo_cnt_r == PHY_RST_CYCLES; endproperty
    a_hrst: assert property (p_hrst) else $error("PHY reset length wrong");
    property p_oe_mdc; $rose(mdio_oe) |-> !mdc; endproperty
    a_oe_mdc: assert property (p_oe_mdc) else $error("frame started with clock high");
endmodule
bind pmmc_top pmmc_top_monitor #(.PHY_RST_CYCLES(PHY_RST_CYCLES)) u_mon (.*);

// ==== test/pmmc_phy_model.sv ====
`timescale 1ns/10ps
module pmmc_phy_model import pmmc_pkg::*; (
    input  wire logic mdc,
    input  wire logic mdio_o,
    input  wire logic mdio_oe,
    output logic      mdio_i
);
    logic [15:0] regs [32];
    logic [15:0] sh = '0;
    logic [16:0] rdw = '0;
    logic [11:0] hdr = '0;
    logic        rd_drv = 1'h0;
    int          n = 0;
    // The line has a pull-up, so it reads high while nobody drives it.
    assign mdio_i = mdio_oe ? mdio_o : (rd_drv ? rdw[16] : 1'h1);
    initial begin
        for (int i = 0; i < 32; i++) regs[i] = 16'hc300 | 16'(i);
    end
    always @(posedge mdc) begin
        sh <= {sh[14:0], mdio_i};
        if (n == 0) n <= (mdio_i == 1'h0) ? 1 : 0;
        else n <= (n == 31) ? 0 : n + 1;
        if (n == 13) hdr <= {sh[10:0], mdio_i};
        if (n == 14) rdw <= {1'h0, regs[hdr[4:0]]};
        if (n == 31 && hdr[11:10] == PMMC_OP_WR && hdr[9:5] == PMMC_PHY_ADDR) begin
            regs[hdr[4:0]] <= {sh[14:0], mdio_i};
        end
    end
    always @(negedge mdc) begin
        if (n == 15 && hdr[11:10] == PMMC_OP_RD && hdr[9:5] == PMMC_PHY_ADDR) rd_drv <= 1'h1;
        else if (n == 0) rd_drv <= 1'h0;
        else if (rd_drv) rdw <= {rdw[15:0], 1'h1};
    end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench import pmmc_pkg::*;;
    typedef struct packed {logic wr; logic [7:0] a, d, r; logic [1:0] br, rr;} pmmc_row_t;
    logic aclk = 1'h0, aresetn = 1'h0, mdc, mdio_i, mdio_o, mdio_oe;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
    logic s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rd, hi;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
    logic [2:0] m;
    pmmc_phy_stat_t phy_stat = 6'h31;
    pmmc_phy_ctl_t phy_ctl, e;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    logic [2:0] modes [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
    pmmc_row_t rows [13] = '{'{0, 8'h04, 0, 8'h00, 0, 0}, '{0, 8'h08, 0, 8'h00, 0, 0},
        '{0, 8'h24, 0, 8'h00, 0, 0}, '{1, 8'h00, 8'h53, 8'h00, 0, 0},
        '{1, 8'h04, 8'h06, 8'h06, 0, 0}, '{1, 8'h00, 8'h00, 8'h00, 0, 0},
        '{1, 8'h04, 8'h05, 8'h06, 0, 0}, '{1, 8'h0c, 8'hff, 8'h31, 0, 0},
        '{1, 8'h1c, 8'h34, 8'h34, 0, 0}, '{1, 8'h20, 8'h12, 8'h12, 0, 0},
        '{1, 8'h14, 8'h01, 8'h01, 0, 0}, '{1, 8'h18, 8'h05, 8'h05, 0, 0},
        '{1, 8'h40, 8'h11, 8'h00, 2'h2, 2'h2}};
    pmmc_top #(.PHY_RST_CYCLES(20)) DUT (.*);
    pmmc_phy_model u_phy (.mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdio_i(mdio_i));
    always #20 aclk = ~aclk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awvalid <= 1'h1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'h1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        r = s_axi_bresp;
    endtask
    task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
    endtask
    task automatic poll(input logic [7:0] a);
        int n;
        n = 0;
        do begin
            axr(a, rd, rr);
            n++;
        end while (rd !== 8'h00 && n < 2000);
        chk(rd, 16'h0000);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 10000) begin
            error_cnt++;
            final_report;
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        e = 9'h13f;
        chk(phy_ctl, e);
        foreach (rows[i]) begin
            if (rows[i].wr) axw(rows[i].a, rows[i].d, br);
            if (rows[i].wr) chk(br, rows[i].br);
            axr(rows[i].a, rd, rr);
            chk({rd, 6'h00, rr}, {rows[i].r, 6'h00, rows[i].rr});
        end
        $display("test registers done");
        axw(8'h00, 8'h53, br);
        foreach (modes[i]) begin
            m = modes[i];
            axw(8'h04, {5'h00, m}, br);
            repeat (2) @(posedge aclk);
            chk(phy_ctl, e);
            axw(8'h08, 8'h01, br);
            phy_stat <= {m, 3'h1};
            poll(8'h08);
            repeat (2) @(posedge aclk);
            e = {1'h1, 2'h0, {3{~m[2]}}, ~m[2] | ~m[1], ~m[2] | ~m[0], 1'h1};
            chk(phy_ctl, e);
            axr(8'h0c, rd, rr);
            chk(rd, {10'h000, m, 3'h1});
        end
        $display("test modes done");
        axw(8'h08, 8'h28, br);
        repeat (2) @(posedge aclk);
        chk(phy_ctl, 9'h1fe);
        axw(8'h08, 8'h00, br);
        axw(8'h10, 8'h01, br);
        repeat (2) @(posedge aclk);
        chk(phy_ctl, 9'h13e);
        axw(8'h10, 8'h00, br);
        axw(8'h00, 8'h00, br);
        axw(8'h08, 8'h20, br);
        repeat (2) @(posedge aclk);
        chk(phy_ctl, 9'h13f);
        $display("test power done");
        axw(8'h24, 8'h01, br);
        axw(8'h24, 8'h02, br);
        poll(8'h24);
        chk(u_phy.regs[5], 16'h1234);
        axr(8'h28, rd, rr);
        chk(rd, 16'h0000);
        axw(8'h18, 8'h09, br);
        axw(8'h24, 8'h02, br);
        poll(8'h24);
        axr(8'h2c, hi, rr);
        axr(8'h28, rd, rr);
        chk({hi, rd}, 16'hc309);
        $display("test management done");
        final_report;
    end
endmodule
